// [ffc_params.svh]
`ifndef FFC_PARAMS_SVH
`define FFC_PARAMS_SVH
// ==========================================================
// widths and depths
`define FFC_DATA_W    32
`define FFC_BUF_DEPTH 8
`endif

// [ffc_pkg.sv]
`include "ffc_params.svh"
package ffc_pkg;
  // ==========================================================
  // top-level state
  typedef struct packed {
    logic                   mode_meta;
    logic                   mode_sync;
    logic                   cap_valid;
    logic [`FFC_DATA_W-1:0] cap_data;
  } ffc_top_st_t;
endpackage

// [ffc_stream_if.sv]
`timescale 1ns/10ps
`include "ffc_params.svh"
// ==========================================================
// valid/ready word stream from the capture stage into the buffer, and from the buffer to the output side
interface ffc_stream_if #(
  parameter int WIDTH = `FFC_DATA_W
) ();
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// [ffc_buf.sv]
`timescale 1ns/10ps
`include "ffc_params.svh"
module ffc_buf
  import ffc_pkg::*;
#(
  parameter int WIDTH = `FFC_DATA_W,
  parameter int DEPTH = `FFC_BUF_DEPTH
) (
  input wire logic   mclk,
  input wire logic   rst_n,
  ffc_stream_if.snk  push,
  ffc_stream_if.src  pop
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [AW:0]   FULL = (AW+1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr_ptr;
    logic [AW-1:0]               rd_ptr;
    logic [AW:0]                 count;
  } ffc_buf_st_t;

  ffc_buf_st_t st;
  ffc_buf_st_t next_st;
  logic        do_push;
  logic        do_pop;

  // ==========================================================
  // storage
  assign push.ready = (st.count != FULL);
  assign pop.valid  = (st.count != '0);
  assign pop.data   = st.mem[st.rd_ptr];
  assign do_push    = push.valid && push.ready;
  assign do_pop     = pop.valid && pop.ready;

  always_comb begin
    next_st = st;
    if (do_push) begin
      next_st.mem[st.wr_ptr] = push.data;
      next_st.wr_ptr = (st.wr_ptr == LAST) ? '0 : st.wr_ptr + 1'b1;
    end
    if (do_pop) begin
      next_st.rd_ptr = (st.rd_ptr == LAST) ? '0 : st.rd_ptr + 1'b1;
    end
    case ({do_push, do_pop})
      2'b10:   next_st.count = st.count + 1'b1;
      2'b01:   next_st.count = st.count - 1'b1;
      default: next_st.count = st.count;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // checks
  property p_no_overfill;
    @(posedge mclk) disable iff (!rst_n)
      (st.count == FULL && !do_pop) |=> (st.count == FULL) && !push.ready;
  endproperty
  a_no_overfill: assert property (p_no_overfill)
    else $error("buffer accepted a word while full");

  property p_word_kept;
    @(posedge mclk) disable iff (!rst_n)
      (do_push && st.count == '0) |=> pop.valid && (pop.data == $past(push.data));
  endproperty
  a_word_kept: assert property (p_word_kept)
    else $error("word pushed into empty buffer not presented");

  property p_no_spurious;
    @(posedge mclk) disable iff (!rst_n)
      (st.count == '0 && !do_push) |=> !pop.valid;
  endproperty
  a_no_spurious: assert property (p_no_spurious)
    else $error("buffer produced a word from nothing");
endmodule

// [ffc_top.sv]
`timescale 1ns/10ps
`include "ffc_params.svh"
// Summary of operation
// - normal mode: issue an input read strobe only while the input empty flag is clear
// - throttle mode: empty flag acts as clock enable so bad words stop
// - never raise the output write enable while the output full flag is set
// - throttle mode: pipeline advances only when input data and output room both allow; normal mode waits only for input data and local room
// - local buffering so no word is dropped and none is invented
// - drive a free-running clock on both carrier fifo clock outputs
// - all fifo strobes, flags and data live on that one rising-edge clock
module ffc_top
  import ffc_pkg::*;
#(
  parameter int WIDTH = `FFC_DATA_W,
  parameter int DEPTH = `FFC_BUF_DEPTH
) (
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic             throttle_mode,
  output wire logic             in_fifo_clk,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             input_empty_flag,
  output wire logic             in_read_strobe,
  output wire logic             out_fifo_clk,
  input  wire logic             output_full_flag,
  output wire logic             out_write_enable,
  output wire logic [WIDTH-1:0] out_data
);
  ffc_top_st_t st;
  ffc_top_st_t next_st;
  logic        room;
  logic        proc_ce;
  logic        cap_load;

  ffc_stream_if #(.WIDTH(WIDTH)) push_if ();
  ffc_stream_if #(.WIDTH(WIDTH)) pop_if ();

  // ==========================================================
  // carrier clocks
  // forwarding mclk keeps the flags synchronous to our own edge, so they
  // need no synchroniser; the mode strap is asynchronous and does
  assign in_fifo_clk  = mclk;
  assign out_fifo_clk = mclk;

  // ==========================================================
  // input side
  assign room     = !st.cap_valid || push_if.ready;
  // throttle mode also waits for output room: stops the input read in the same cycle as the output write
  assign proc_ce  = room && (!st.mode_sync || !output_full_flag);
  assign in_read_strobe = st.mode_sync ? proc_ce
                                       : (room && !input_empty_flag);
  assign cap_load = in_read_strobe && !input_empty_flag;

  assign push_if.valid = st.cap_valid;
  assign push_if.data  = st.cap_data;

  always_comb begin
    next_st = st;
    next_st.mode_meta = throttle_mode;
    next_st.mode_sync = st.mode_meta;
    if (st.cap_valid && push_if.ready) begin
      next_st.cap_valid = 1'b0;
    end
    if (cap_load) begin
      next_st.cap_valid = 1'b1;
      next_st.cap_data  = in_data;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // buffer
  ffc_buf #(
    .WIDTH (WIDTH),
    .DEPTH (DEPTH)
  ) u_buf (
    .mclk  (mclk),
    .rst_n (rst_n),
    .push  (push_if.snk),
    .pop   (pop_if.src)
  );

  // ==========================================================
  // output side
  // full is a same-edge flag: decided combinationally, never a cycle late
  assign pop_if.ready     = !output_full_flag;
  assign out_write_enable = pop_if.valid && !output_full_flag;
  assign out_data         = pop_if.data;

  // ==========================================================
  // checks
  sequence s_full_run;
    output_full_flag [*2];
  endsequence

  sequence s_read_taken;
    in_read_strobe && !input_empty_flag && !st.mode_sync;
  endsequence

  sequence s_norm_ready;
    !st.mode_sync && room && !input_empty_flag;
  endsequence

  sequence s_thr_ready;
    st.mode_sync && room && !output_full_flag;
  endsequence

  sequence s_head_blocked;
    pop_if.valid && output_full_flag;
  endsequence

  sequence s_write_then_full;
    out_write_enable ##1 output_full_flag;
  endsequence

  property p_rd_gate;
    @(posedge mclk) disable iff (!rst_n)
      (!st.mode_sync && input_empty_flag) |-> !in_read_strobe;
  endproperty
  a_rd_gate: assert property (p_rd_gate)
    else $error("read strobe raised on empty input fifo");

  property p_ce_hold;
    @(posedge mclk) disable iff (!rst_n)
      (st.mode_sync && input_empty_flag && !st.cap_valid) |=> !st.cap_valid;
  endproperty
  a_ce_hold: assert property (p_ce_hold)
    else $error("word from empty fifo entered pipeline");

  property p_wr_gate;
    @(posedge mclk) disable iff (!rst_n)
      s_full_run |-> !out_write_enable && !$past(out_write_enable);
  endproperty
  a_wr_gate: assert property (p_wr_gate)
    else $error("write enable raised while output full");

  property p_throttle_stall;
    @(posedge mclk) disable iff (!rst_n)
      (st.mode_sync && output_full_flag) |-> !in_read_strobe;
  endproperty
  a_throttle_stall: assert property (p_throttle_stall)
    else $error("throttled pipeline advanced without output room");

  property p_capture;
    @(posedge mclk) disable iff (!rst_n)
      s_read_taken |=> st.cap_valid && (st.cap_data == $past(in_data));
  endproperty
  a_capture: assert property (p_capture)
    else $error("read word not captured on the strobe edge");

  property p_no_drop;
    @(posedge mclk) disable iff (!rst_n)
      (st.cap_valid && !push_if.ready) |=> st.cap_valid && $stable(st.cap_data);
  endproperty
  a_no_drop: assert property (p_no_drop)
    else $error("captured word lost under back-pressure");

  property p_write_drains;
    @(posedge mclk) disable iff (!rst_n)
      (pop_if.valid && !output_full_flag) |-> out_write_enable ##0 (out_data == pop_if.data);
  endproperty
  a_write_drains: assert property (p_write_drains)
    else $error("buffered word held back despite output room");

  property p_rd_go;
    @(posedge mclk) disable iff (!rst_n)
      s_norm_ready |-> in_read_strobe;
  endproperty
  a_rd_go: assert property (p_rd_go)
    else $error("read held back although data and room were there");

  property p_thr_go;
    @(posedge mclk) disable iff (!rst_n)
      s_thr_ready |-> in_read_strobe;
  endproperty
  a_thr_go: assert property (p_thr_go)
    else $error("throttled pipeline stalled with room on both sides");

  // in throttle mode a read that meets a non-empty fifo must fill the capture stage
  property p_thr_capture;
    @(posedge mclk) disable iff (!rst_n)
      (st.mode_sync && in_read_strobe && !input_empty_flag)
        |=> st.cap_valid && (st.cap_data == $past(in_data));
  endproperty
  a_thr_capture: assert property (p_thr_capture)
    else $error("enabled read word not captured in throttle mode");

  property p_no_room;
    @(posedge mclk) disable iff (!rst_n)
      !room |-> !in_read_strobe;
  endproperty
  a_no_room: assert property (p_no_room)
    else $error("read strobe raised with no room to keep the word");

  property p_head_hold;
    @(posedge mclk) disable iff (!rst_n)
      s_head_blocked |=> pop_if.valid && $stable(out_data);
  endproperty
  a_head_hold: assert property (p_head_hold)
    else $error("head word changed while the output fifo was full");

  property p_cap_clear;
    @(posedge mclk) disable iff (!rst_n)
      (st.cap_valid && push_if.ready && !cap_load) |=> !st.cap_valid;
  endproperty
  a_cap_clear: assert property (p_cap_clear)
    else $error("captured word handed on twice");

  property p_write_stop;
    @(posedge mclk) disable iff (!rst_n)
      s_write_then_full |-> !out_write_enable;
  endproperty
  a_write_stop: assert property (p_write_stop)
    else $error("write enable kept up after output became full");

  property p_no_empty_write;
    @(posedge mclk) disable iff (!rst_n)
      !pop_if.valid |-> !out_write_enable;
  endproperty
  a_no_empty_write: assert property (p_no_empty_write)
    else $error("write enable raised with nothing buffered");
endmodule

// [ffc_carrier.sv]
`timescale 1ns/10ps
// ==========================================================
// carrier input and output fifos
module ffc_carrier
  import ffc_pkg::*;
#(
  parameter logic [31:0] BASE = 32'hA5000000
) (
  input  wire logic        in_fifo_clk,
  input  wire logic        out_fifo_clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  avail,
  input  wire logic        full_req,
  input  wire logic        in_read_strobe,
  input  wire logic        out_write_enable,
  input  wire logic [31:0] out_data,
  output wire logic        input_empty_flag,
  output wire logic [31:0] in_data,
  output wire logic        output_full_flag
);
  logic [7:0]  idx;
  logic [31:0] got [0:127];
  int          n_got;
  int          n_lost;
  // empty held during reset so nothing is read before release
  assign input_empty_flag = !rst_n || (idx >= avail);
  // an empty read returns the inverse of the last word, never a stale match
  assign in_data = input_empty_flag ? ~(BASE + idx - 32'h1) : BASE + idx;
  assign output_full_flag = full_req;
  always @(posedge in_fifo_clk or negedge rst_n) begin
    if (!rst_n) idx <= 8'h00;
    else if (in_read_strobe && !input_empty_flag) idx <= idx + 8'h01;
  end
  always @(posedge out_fifo_clk or negedge rst_n) begin
    if (!rst_n) begin
      n_got  <= 0;
      n_lost <= 0;
    end else if (out_write_enable && output_full_flag) begin
      n_lost <= n_lost + 1;
    end else if (out_write_enable) begin
      got[n_got] <= out_data;
      n_got      <= n_got + 1;
    end
  end
endmodule

// [ffc_tb.sv]
`timescale 1ns/10ps
// ==========================================================
// bench for the fifo flow control block
module tb;
  import ffc_pkg::*;
  localparam logic [31:0] BASE = 32'hA5000000;
  logic mclk = 0, rst_n = 0, throttle_mode = 0, full_req = 0;
  logic [7:0] avail = 8'h00;
  logic [2:0] mh = 3'h0;
  logic in_fifo_clk, out_fifo_clk, input_empty_flag, in_read_strobe;
  logic output_full_flag, out_write_enable;
  logic [31:0] in_data, out_data;
  int errors = 0, comparisons = 0, bad = 0, cycles = 0;
  ffc_top dut_u (.mclk(mclk), .rst_n(rst_n), .throttle_mode(throttle_mode),
    .in_fifo_clk(in_fifo_clk), .in_data(in_data), .input_empty_flag(input_empty_flag),
    .in_read_strobe(in_read_strobe), .out_fifo_clk(out_fifo_clk),
    .output_full_flag(output_full_flag), .out_write_enable(out_write_enable),
    .out_data(out_data));
  ffc_carrier #(.BASE(BASE)) car_u (.in_fifo_clk(in_fifo_clk), .out_fifo_clk(out_fifo_clk),
    .rst_n(rst_n), .avail(avail), .full_req(full_req), .in_read_strobe(in_read_strobe),
    .out_write_enable(out_write_enable), .out_data(out_data),
    .input_empty_flag(input_empty_flag), .in_data(in_data),
    .output_full_flag(output_full_flag));
  initial begin
    forever #5 mclk = ~mclk;
  end
  // strobe watch skips the mode synchroniser's settling window
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    mh <= {mh[1:0], throttle_mode};
    if (rst_n && out_write_enable && output_full_flag) bad <= bad + 1;
    if (rst_n && mh == 3'h0 && !throttle_mode && in_read_strobe && input_empty_flag)
      bad <= bad + 1;
    if (cycles == 5000) begin
      errors++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic verify(input int total);
    for (int w = 0; w < 300 && car_u.n_got < total; w++) @(negedge mclk);
    for (int k = 0; k < total; k++) check("word", car_u.got[k], BASE + k);
    check("count", 32'(car_u.n_got), 32'(total));
    check("lost", 32'(car_u.n_lost), 32'h0);
    check("strobe", 32'(bad), 32'h0);
  endtask
  task automatic t_clock();
    @(posedge mclk) #1;
    check("in clk hi", in_fifo_clk, 32'h1);
    check("out clk hi", out_fifo_clk, 32'h1);
    @(negedge mclk) #1;
    check("in clk lo", in_fifo_clk, 32'h0);
    check("out clk lo", out_fifo_clk, 32'h0);
  endtask
  // gap leaves the input empty between words; throttle mode then offers junk reads
  task automatic t_flow(input logic mode, input int words, input int gap);
    @(negedge mclk) throttle_mode = mode;
    repeat (4) @(negedge mclk);
    for (int i = 0; i < words; i++) begin
      avail = avail + 8'h01;
      repeat (gap + 1) @(negedge mclk);
    end
    verify(avail);
  endtask
  // far side stalls: in normal mode the buffer fills until it refuses, throttle mode takes nothing; then drains on a ragged full flag
  task automatic t_stall(input logic mode, input int taken);
    logic [7:0] start;
    @(negedge mclk) throttle_mode = mode;
    full_req = 1;
    repeat (4) @(negedge mclk);
    start = car_u.idx;
    avail = avail + 8'h14;
    repeat (30) @(negedge mclk);
    check("taken", 32'(car_u.idx), 32'(start) + taken);
    for (int i = 0; i < 60; i++) @(negedge mclk) full_req = ~full_req;
    @(negedge mclk) full_req = 0;
    verify(avail);
  endtask
  initial begin
    repeat (8) @(negedge mclk);
    rst_n = 1;
    t_clock();
    t_flow(0, 8, 0);
    t_flow(0, 6, 2);
    t_stall(0, 9);
    t_flow(1, 8, 0);
    t_flow(1, 6, 2);
    t_stall(1, 0);
    report_and_stop();
  end
endmodule
